// file: hdl/scwg_top.sv
`include "scwg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scwg_top
    import scwg_pkg::*;
#(
    parameter int FETCH_LIMIT = `SCWG_AUTO_FETCHES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // CPU bus from the core, same clock
    input wire scwg_bus_s CPU_BUS,
    input wire logic PERIPH_HIT,
    // Read data return
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    // Wait request to the core
    output logic WAIT_N,
    // Settings for other units
    output logic [7:0] CS_WINDOW,
    output logic [7:0] MISC_OPTIONS,
    output logic AUTO_WAIT
);

    // Field count doubled: 00,01,10,11 -> 0,2,4,6
    function automatic scwg_count_t twice(input logic [1:0] f);
        twice = {1'b0, f, 1'b0};
    endfunction

    // Full low-byte port match
    function automatic logic port_hit(input logic [15:0] a, input logic [7:0] p);
        port_hit = (a[7:0] == p);
    endfunction

    // Strobe history for edge detection
    scwg_bus_s prev_q;
    scwg_bus_s prev_d;

    always_comb begin
        prev_d = CPU_BUS;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_q <= '{addr: 16'h0000, data: 8'h00, default: 1'b1};
        end else begin
            prev_q <= prev_d;
        end
    end

    // Decoded bus events
    logic fetch_fall;
    logic fetch_rise;
    logic mem_fall;
    logic io_fall;
    logic wr_fall;
    logic io_cycle;
    logic hit_ptr;
    logic hit_data;
    logic fetch_start;
    logic ack_start;
    logic mem_start;
    logic io_start;
    logic vec_start;

    // An acknowledge is a fetch strobe without memory request
    always_comb begin
        fetch_fall = prev_q.opcode_fetch_strobe_n & ~CPU_BUS.opcode_fetch_strobe_n;
        fetch_rise = ~prev_q.opcode_fetch_strobe_n & CPU_BUS.opcode_fetch_strobe_n;
        mem_fall = prev_q.mem_request_strobe_n & ~CPU_BUS.mem_request_strobe_n;
        io_fall = prev_q.io_request_strobe_n & ~CPU_BUS.io_request_strobe_n;
        io_cycle = ~CPU_BUS.io_request_strobe_n & CPU_BUS.opcode_fetch_strobe_n;
        wr_fall = io_cycle & prev_q.wr_n & ~CPU_BUS.wr_n;
        hit_ptr = port_hit(CPU_BUS.addr, `SCWG_PTR_PORT);
        hit_data = port_hit(CPU_BUS.addr, `SCWG_DATA_PORT);
        fetch_start = fetch_fall & ~CPU_BUS.mem_request_strobe_n;
        ack_start = fetch_fall & CPU_BUS.mem_request_strobe_n;
        mem_start = mem_fall & CPU_BUS.opcode_fetch_strobe_n;
        io_start = io_fall & CPU_BUS.opcode_fetch_strobe_n;
        vec_start = io_fall & ~CPU_BUS.opcode_fetch_strobe_n;
    end

    // Configuration registers
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] wait_q;
    logic [7:0] wait_d;
    logic [7:0] memwin_q;
    logic [7:0] memwin_d;
    logic [7:0] cswin_q;
    logic [7:0] cswin_d;
    logic [7:0] misc_q;
    logic [7:0] misc_d;
    logic auto_q;
    logic auto_d;
    logic [4:0] fetches_q;
    logic [4:0] fetches_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic [7:0] wait_eff;

    // Power-on period forces all ones until cleared or written
    always_comb begin
        wait_eff = auto_q ? `SCWG_AUTO_VALUE : wait_q;
    end

    // Register writes, pointer held between data accesses
    always_comb begin
        ptr_d = ptr_q;
        wait_d = wait_q;
        memwin_d = memwin_q;
        cswin_d = cswin_q;
        misc_d = misc_q;
        auto_d = auto_q;
        fetches_d = fetches_q;
        if (auto_q && fetch_rise) begin
            fetches_d = fetches_q + 5'd1;
            if (fetches_d == 5'(FETCH_LIMIT)) begin
                auto_d = 1'b0;
            end
        end
        if (wr_fall && hit_ptr) begin
            ptr_d = CPU_BUS.data;
        end
        if (wr_fall && hit_data) begin
            // Reserved pointer values write nothing
            unique case (ptr_q)
                `SCWG_IDX_WAIT: begin
                    wait_d = CPU_BUS.data;
                    auto_d = 1'b0;
                end
                `SCWG_IDX_MEMWIN: memwin_d = CPU_BUS.data;
                `SCWG_IDX_CSWIN: cswin_d = CPU_BUS.data;
                `SCWG_IDX_MISC: misc_d = CPU_BUS.data;
                default: ;
            endcase
        end
    end

    // Read data registered every clock; reserved index reads zero
    always_comb begin
        rd_d = 8'h00;
        if (hit_ptr) begin
            rd_d = ptr_q;
        end else begin
            unique case (ptr_q)
                `SCWG_IDX_WAIT: rd_d = wait_eff;
                `SCWG_IDX_MEMWIN: rd_d = memwin_q;
                `SCWG_IDX_CSWIN: rd_d = cswin_q;
                `SCWG_IDX_MISC: rd_d = misc_q;
                default: rd_d = 8'h00;
            endcase
        end
    end

    // Reset covers power-on and the external reset alike
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ptr_q <= `SCWG_RST_PTR;
            wait_q <= `SCWG_RST_WAIT;
            memwin_q <= `SCWG_RST_MEMWIN;
            cswin_q <= `SCWG_RST_CSWIN;
            misc_q <= `SCWG_RST_MISC;
            auto_q <= 1'b1;
            fetches_q <= 5'd0;
            rd_q <= 8'h00;
        end else begin
            ptr_q <= ptr_d;
            wait_q <= wait_d;
            memwin_q <= memwin_d;
            cswin_q <= cswin_d;
            misc_q <= misc_d;
            auto_q <= auto_d;
            fetches_q <= fetches_d;
            rd_q <= rd_d;
        end
    end

    // Wait counts from the effective control value
    logic in_window;
    logic onchip_io;
    logic return_armed;
    scwg_count_t mem_waits;
    scwg_count_t return_more;

    always_comb begin
        in_window = (CPU_BUS.addr[15:12] <= memwin_q[`SCWG_F_WIN_HI]) &&
                    (CPU_BUS.addr[15:12] >= memwin_q[`SCWG_F_WIN_LO]);
        onchip_io = hit_ptr | hit_data | PERIPH_HIT;
        mem_waits = in_window ? {2'b00, wait_eff[`SCWG_F_MEM]} : 4'd0;
        return_armed = wait_eff[7];
        // Total return waits 2 or 4, one already spent on the check
        return_more = wait_eff[6] ? 4'd3 : 4'd1;
    end

    // Wait generator
    scwg_wait_e state_q;
    scwg_wait_e state_d;
    scwg_count_t cnt_q;
    scwg_count_t cnt_d;
    logic prefix_q;
    logic prefix_d;
    logic infetch_q;
    logic infetch_d;
    logic check_q;
    logic check_d;
    scwg_count_t load;
    logic load_en;
    logic check_new;

    // Pick the count for the cycle that starts now
    always_comb begin
        load = 4'd0;
        load_en = 1'b0;
        check_new = 1'b0;
        if (fetch_start) begin
            check_new = prefix_q & return_armed;
            load = mem_waits + {3'b000, wait_eff[`SCWG_F_OPX]} + {3'b000, check_new};
            load_en = 1'b1;
        end else if (ack_start) begin
            load = twice(wait_eff[`SCWG_F_DAISY]);
            load_en = 1'b1;
        end else if (vec_start) begin
            load = {3'b000, wait_eff[`SCWG_F_VECTOR]};
            load_en = 1'b1;
        end else if (mem_start) begin
            load = mem_waits;
            load_en = 1'b1;
        end else if (io_start) begin
            load = onchip_io ? 4'd0 : twice(wait_eff[`SCWG_F_IO]);
            load_en = 1'b1;
        end
    end

    // One clock of wait request per counted wait
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        check_d = check_q;
        prefix_d = prefix_q;
        infetch_d = infetch_q;
        if (fetch_start) begin
            infetch_d = 1'b1;
        end
        // Opcode byte is valid as the fetch strobe ends
        if (fetch_rise) begin
            infetch_d = 1'b0;
            if (infetch_q) begin
                prefix_d = (prev_q.data == `SCWG_OP_PREFIX);
            end
        end
        unique case (state_q)
            WS_IDLE: begin
                if (load_en && load != 4'd0) begin
                    state_d = WS_COUNT;
                    cnt_d = load;
                    check_d = check_new;
                end
            end
            WS_COUNT: begin
                if (cnt_q == 4'd1) begin
                    // Last wait of a fetch after the prefix looks at the opcode
                    if (check_q && CPU_BUS.data == `SCWG_OP_RETURN) begin
                        cnt_d = return_more;
                    end else begin
                        state_d = WS_IDLE;
                        cnt_d = 4'd0;
                    end
                    check_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 4'd1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= WS_IDLE;
            cnt_q <= 4'd0;
            check_q <= 1'b0;
            prefix_q <= 1'b0;
            infetch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            check_q <= check_d;
            prefix_q <= prefix_d;
            infetch_q <= infetch_d;
        end
    end

    // Outputs; data enable is combinational so it ends with the strobe
    always_comb begin
        WAIT_N = (state_q != WS_COUNT);
        DATA_OE = io_cycle & ~CPU_BUS.rd_n & (hit_ptr | hit_data);
        DATA_OUT = rd_q;
        CS_WINDOW = cswin_q;
        MISC_OPTIONS = misc_q;
        AUTO_WAIT = auto_q;
    end

endmodule // scwg_top

`default_nettype wire

// file: include/scwg_map.svh
`ifndef SCWG_MAP_SVH
`define SCWG_MAP_SVH

// I/O ports, full 8-bit decode
`define SCWG_PTR_PORT 8'hee
`define SCWG_DATA_PORT 8'hef

// Indirect register numbers
`define SCWG_IDX_WAIT 8'h00
`define SCWG_IDX_MEMWIN 8'h01
`define SCWG_IDX_CSWIN 8'h02
`define SCWG_IDX_MISC 8'h03

// Reset values
`define SCWG_RST_PTR 8'h00
`define SCWG_RST_WAIT 8'h00
`define SCWG_RST_MEMWIN 8'hf0
`define SCWG_RST_CSWIN 8'h0f
`define SCWG_RST_MISC 8'h01
`define SCWG_AUTO_VALUE 8'hff

// Wait control fields
`define SCWG_F_DAISY 7:6
`define SCWG_F_VECTOR 5
`define SCWG_F_OPX 4
`define SCWG_F_MEM 3:2
`define SCWG_F_IO 1:0

// Memory window fields
`define SCWG_F_WIN_HI 7:4
`define SCWG_F_WIN_LO 3:0

// Opcodes of the return sequence
`define SCWG_OP_PREFIX 8'hed
`define SCWG_OP_RETURN 8'h4d

// Opcode fetches in the power-on period
`define SCWG_AUTO_FETCHES 16

`endif

// file: include/scwg_pkg.sv
package scwg_pkg;

    // Wait generator states
    typedef enum logic {
        WS_IDLE,
        WS_COUNT
    } scwg_wait_e;

    // CPU bus strobes and buses, active-low strobes
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic opcode_fetch_strobe_n;
        logic mem_request_strobe_n;
        logic io_request_strobe_n;
        logic rd_n;
        logic wr_n;
    } scwg_bus_s;

    typedef logic [3:0] scwg_count_t;

endpackage

// file: sim/scwg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module scwg_cpu_model
    import scwg_pkg::*;
(
    // Clock and answers
    input wire logic clk,
    input wire logic wait_n,
    input wire logic [7:0] data_out,
    // Bus toward the device
    output var scwg_bus_s bus
);
    // Idle bus
    initial bus = '{addr: 16'h0000, data: 8'h00, default: 1'b1};
    // Wait clocks over a fixed hold; longest run is eight
    task automatic hold(output logic [7:0] n);
        n = 8'h00;
        repeat (10) begin
            @(negedge clk);
            n = n + 8'(wait_n === 1'b0);
        end
    endtask
    // Kinds: 0 memory, 1 fetch, 2 I/O write, 3 I/O read, 4 acknowledge then vector
    task automatic run(input int k, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] n, output logic [7:0] nv, output logic [7:0] rd);
        @(negedge clk);
        bus = '{addr: a, data: d, mem_request_strobe_n: k > 1, opcode_fetch_strobe_n: k != 1 && k != 4,
            io_request_strobe_n: k < 2 || k == 4, rd_n: k == 2 || k == 4, wr_n: 1'b1};
        if (k == 2) begin
            @(negedge clk);
            bus.wr_n = 1'b0;
        end
        hold(n);
        rd = data_out;
        nv = 8'h00;
        if (k == 4) begin
            bus.io_request_strobe_n = 1'b0;
            hold(nv);
        end
        // Released: flipped values so stale bytes never match
        bus = '{addr: ~a, data: ~d, default: 1'b1};
        @(negedge clk);
    endtask
endmodule // scwg_cpu_model
`default_nettype wire

// file: sim/scwg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scwg_top_asserts
    import scwg_pkg::*;
#(
    parameter int FETCH_LIMIT = 16
) (
    // Clock, reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    input wire scwg_bus_s CPU_BUS,
    input wire logic PERIPH_HIT,
    // Results
    input wire logic [7:0] DATA_OUT,
    input wire logic DATA_OE,
    input wire logic WAIT_N,
    input wire logic [7:0] CS_WINDOW,
    input wire logic [7:0] MISC_OPTIONS,
    input wire logic AUTO_WAIT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Strobe shorthands
    wire logic io_n = CPU_BUS.io_request_strobe_n;
    wire logic mr_n = CPU_BUS.mem_request_strobe_n;
    wire logic f_n = CPU_BUS.opcode_fetch_strobe_n;
    wire logic own = CPU_BUS.addr[7:1] == 7'h77;
    // Bus cycles and the wait request
    property p_oe; DATA_OE == (!io_n && !CPU_BUS.rd_n && f_n && own); endproperty
    a_oe: assert property (p_oe) else $error("read enable wrong");
    property p_own; $fell(io_n) && f_n && own |=> WAIT_N [*8]; endproperty
    a_own: assert property (p_own) else $error("wait on own port");
    property p_hit; $fell(io_n) && f_n && PERIPH_HIT |=> WAIT_N [*8]; endproperty
    a_hit: assert property (p_hit) else $error("wait on peripheral");
    property p_auto; !$rose(AUTO_WAIT); endproperty
    a_auto: assert property (p_auto) else $error("auto period came back");
    property p_len; $fell(WAIT_N) |-> ##[1:8] WAIT_N; endproperty
    a_len: assert property (p_len) else $error("wait too long");
    property p_cause; $fell(WAIT_N) |-> $past(io_n, 2) > $past(io_n) || $past(mr_n, 2) > $past(mr_n)
        || $past(f_n, 2) > $past(f_n); endproperty
    a_cause: assert property (p_cause) else $error("wait without cycle");
    property p_cfg; $changed(CS_WINDOW) || $changed(MISC_OPTIONS)
        |-> $past(!CPU_BUS.wr_n && !io_n && CPU_BUS.addr[7:0] == 8'hef); endproperty
    a_cfg: assert property (p_cfg) else $error("setting changed unwritten");
    property p_aio; AUTO_WAIT && $fell(io_n) && f_n && !PERIPH_HIT && !own |=> !WAIT_N [*6] ##1 WAIT_N; endproperty
    a_aio: assert property (p_aio) else $error("power-on I/O waits wrong");
endmodule // scwg_top_asserts
bind scwg_top scwg_top_asserts #(.FETCH_LIMIT(FETCH_LIMIT)) scwg_top_asserts_inst (.CLK(CLK), .RST(RST),
    .CPU_BUS(CPU_BUS), .PERIPH_HIT(PERIPH_HIT), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .WAIT_N(WAIT_N),
    .CS_WINDOW(CS_WINDOW), .MISC_OPTIONS(MISC_OPTIONS), .AUTO_WAIT(AUTO_WAIT));
`default_nettype wire

// file: sim/system_config_wait_state_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_config_wait_state_gen_tb;
    import scwg_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PERIPH_HIT = 1'b0;
    scwg_bus_s CPU_BUS;
    logic [7:0] DATA_OUT, CS_WINDOW, MISC_OPTIONS;
    logic DATA_OE, WAIT_N, AUTO_WAIT;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    // Bench model of the bank
    logic [7:0] regs [4];
    logic [7:0] seq [4] = '{8'hed, 8'h4d, 8'hed, 8'h00};
    logic [7:0] ptr;
    logic in_auto, pend;
    int fetches;
    always #2 CLK = ~CLK;
    // Fetch limit cut to 3 to keep the run short
    scwg_top #(.FETCH_LIMIT(3)) scwg_top_inst (.CLK(CLK), .RST(RST), .CPU_BUS(CPU_BUS), .PERIPH_HIT(PERIPH_HIT),
        .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .WAIT_N(WAIT_N), .CS_WINDOW(CS_WINDOW),
        .MISC_OPTIONS(MISC_OPTIONS), .AUTO_WAIT(AUTO_WAIT));
    scwg_cpu_model scwg_cpu_model_inst (.clk(CLK), .wait_n(WAIT_N), .data_out(DATA_OUT), .bus(CPU_BUS));
    task automatic close_out;
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Reset the device and the model
    task automatic do_reset;
        RST = 1'b1;
        repeat (12) @(negedge CLK);
        RST = 1'b0;
        regs = '{8'h00, 8'hf0, 8'h0f, 8'h01};
        ptr = 8'h00;
        in_auto = 1'b1;
        pend = 1'b0;
        fetches = 0;
    endtask
    // Port accesses with random ignored high address byte
    task automatic wrp(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] n, nv, rd;
        scwg_cpu_model_inst.run(2, {8'($urandom), p}, v, n, nv, rd);
        if (p == 8'hee)
            ptr = v;
        else if (ptr < 4) begin
            regs[ptr[1:0]] = v;
            if (ptr == 8'h00)
                in_auto = 1'b0;
        end
    endtask
    task automatic rdp(input logic [7:0] p);
        logic [7:0] n, nv, rd, e;
        e = (p == 8'hee) ? ptr : (ptr > 3) ? 8'h00 : (ptr == 8'h00 && in_auto) ? 8'hff : regs[ptr[1:0]];
        scwg_cpu_model_inst.run(3, {8'($urandom), p}, 8'h00, n, nv, rd);
        chk("read data", e, rd);
        chk("port waits", 8'h00, n);
    endtask
    // One bus cycle, wait count worked out from the model
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] n, nv, rd, w;
        int e;
        w = in_auto ? 8'hff : regs[0];
        e = (a[15:12] <= regs[1][7:4] && a[15:12] >= regs[1][3:0]) ? w[3:2] : 0;
        if (k == 1)
            e = e + w[4] + (pend && w[7] ? (d == 8'h4d ? (w[6] ? 4 : 2) : 1) : 0);
        if (k == 3)
            e = (a[7:1] == 7'h77 || PERIPH_HIT) ? 0 : 2 * w[1:0];
        if (k == 4)
            e = 2 * w[7:6];
        scwg_cpu_model_inst.run(k, a, d, n, nv, rd);
        chk("wait clocks", 8'(e), n);
        chk("vector waits", 8'(k == 4 && w[5]), nv);
        if (k == 1 || k == 4) begin
            pend = d == 8'hed;
            fetches++;
            if (in_auto && fetches >= 3) begin
                in_auto = 1'b0;
                regs[0] = 8'h00;
            end
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(6185));
        do_reset;
        rdp(8'hee);
        for (int i = 0; i < 4; i++) begin
            wrp(8'hee, 8'(i));
            rdp(8'hef);
        end
        chk("auto flag", 8'h01, {7'h00, AUTO_WAIT});
        op(0, 16'h9abc, 8'h00);
        op(3, 16'h0010, 8'h00);
        repeat (3) op(1, 16'($urandom), 8'h00);
        chk("auto flag", 8'h00, {7'h00, AUTO_WAIT});
        wrp(8'hee, 8'h00);
        rdp(8'hef);
        // Random settings against every kind of cycle
        repeat (30) begin
            wrp(8'hee, 8'h00);
            wrp(8'hef, 8'($urandom));
            wrp(8'hee, 8'h01);
            wrp(8'hef, 8'($urandom));
            rdp(8'hef);
            op(0, 16'($urandom), 8'h00);
            op(1, 16'($urandom), 8'h00);
            PERIPH_HIT = 1'($urandom);
            op(3, {8'($urandom), 8'($urandom) & 8'hdf}, 8'h00);
            PERIPH_HIT = 1'b0;
            op(4, 16'h0000, 8'h00);
        end
        // Return sequence with two and four settle waits
        for (int f = 2; f < 4; f++) begin
            wrp(8'hee, 8'h00);
            wrp(8'hef, {2'(f), 6'h00});
            foreach (seq[j]) op(1, 16'h0100, seq[j]);
        end
        // Reserved pointer is kept but its data port is dead
        wrp(8'hee, 8'h05);
        wrp(8'hef, 8'ha5);
        rdp(8'hef);
        rdp(8'hee);
        wrp(8'hee, 8'h02);
        wrp(8'hef, 8'h3c);
        wrp(8'hee, 8'h03);
        wrp(8'hef, 8'h06);
        chk("cs window", regs[2], CS_WINDOW);
        chk("misc", regs[3], MISC_OPTIONS);
        // Reset in mid-run, then a write inside the all-ones period
        do_reset;
        rdp(8'hee);
        wrp(8'hee, 8'h01);
        rdp(8'hef);
        chk("cs window", 8'h0f, CS_WINDOW);
        wrp(8'hee, 8'h00);
        wrp(8'hef, 8'h05);
        repeat (3) op(1, 16'h0000, 8'h00);
        rdp(8'hef);
        close_out;
    end
    // Hang guard, far above the run length
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            close_out;
        end
    end
endmodule // system_config_wait_state_gen_tb
`default_nettype wire
